/* File: design/power_condition_timer_cmd.sv */
// Task-file command interpreter for the set-timer and set-state power-condition
// subcommands of set-features. Keeps current and saved settings per condition.
// Assumes the task-file master and the capability inputs run on mclk_i.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Parameter low nibble 2h selects timer programming
// - Update applies only to the identified condition
// - Units bit: 0 is 100 ms, 1 minute
// - Timer is high byte then low byte
// - Bit 5 enables, bit 4 saves
// - Success writes timer into current setting
// - Set-timer enables current only if enable and nonzero
// - Save copies current timer and enable flag
// - Out-of-range values clamp to min or max
// - Range is zero to 3BFFC4h ticks
// - Abort: feature off, bad condition, unsavable save
// - Abort leaves all settings untouched
// - Set-state enables or disables current timer
// - Set-state save copies enabled flag
// - Parameter low nibble 3h selects set-state
module power_condition_timer_cmd (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire pcond_pkg::tf_req_s tf_req_i,
  output logic [7:0] tf_rdata_o,
  input wire logic extended_power_conditions_i,
  input wire logic [pcond_pkg::NUM_COND-1:0] cond_supported_i,
  input wire logic [pcond_pkg::NUM_COND-1:0] cond_changeable_i,
  input wire logic [pcond_pkg::NUM_COND-1:0] cond_savable_i,
  input wire logic [pcond_pkg::COND_IDX_W-1:0] query_cond_i,
  output pcond_pkg::cond_setting_s query_o,
  output logic busy_o,
  output logic cmd_done_o
);

  typedef enum logic {S_IDLE, S_EXEC} cmd_state_e;

  cmd_state_e state;
  logic [7:0] subcommand_select;
  logic [7:0] condition_identifier;
  logic [7:0] subcommand_parameters;
  logic [7:0] timer_value_low;
  logic [7:0] timer_value_high;
  logic [7:0] drive_select;
  logic [7:0] opcode;
  logic abort_flag;
  logic err_flag;
  pcond_pkg::cond_setting_s settings [pcond_pkg::NUM_COND];

  logic host_wr;
  logic start_cmd;
  logic exec;
  logic [pcond_pkg::COND_IDX_W-1:0] cmd_idx;
  logic [3:0] sub_code;
  logic is_set_timer;
  logic is_set_state;
  logic cond_ok;
  logic save_req;
  logic enable_req;
  logic abort_now;
  logic [pcond_pkg::TIMER_W-1:0] scaled;
  pcond_pkg::cond_setting_s next_entry;

  // Status byte as the host sees it
  function automatic logic [7:0] status_byte(input logic busy, input logic err);
    logic [7:0] s;
    s = 8'h00;
    s[pcond_pkg::ST_BUSY_BIT] = busy;
    s[pcond_pkg::ST_READY_BIT] = 1'b1;
    s[pcond_pkg::ST_FAULT_BIT] = 1'b0;
    s[pcond_pkg::ST_ERR_BIT] = err;
    return s;
  endfunction

  // Task-file writes are ignored while a command is running
  assign host_wr = tf_req_i.wr && (state == S_IDLE);
  assign start_cmd = host_wr && (tf_req_i.addr == pcond_pkg::TF_OPCODE_STATUS);
  assign exec = (state == S_EXEC);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      subcommand_select <= pcond_pkg::REG_RESET;
      condition_identifier <= pcond_pkg::REG_RESET;
      subcommand_parameters <= pcond_pkg::REG_RESET;
      timer_value_low <= pcond_pkg::REG_RESET;
      timer_value_high <= pcond_pkg::REG_RESET;
      drive_select <= pcond_pkg::REG_RESET;
      opcode <= pcond_pkg::REG_RESET;
    end else if (host_wr) begin
      unique case (tf_req_i.addr)
        pcond_pkg::TF_FEATURE_ERROR: subcommand_select <= tf_req_i.wdata;
        pcond_pkg::TF_COND_ID: condition_identifier <= tf_req_i.wdata;
        pcond_pkg::TF_PARAMS: subcommand_parameters <= tf_req_i.wdata;
        pcond_pkg::TF_TIMER_LOW: timer_value_low <= tf_req_i.wdata;
        pcond_pkg::TF_TIMER_HIGH: timer_value_high <= tf_req_i.wdata;
        pcond_pkg::TF_DRIVE_SEL: drive_select <= tf_req_i.wdata;
        pcond_pkg::TF_OPCODE_STATUS: opcode <= tf_req_i.wdata;
        default: begin
        end
      endcase
    end
  end

  // Two-state sequencer: the opcode write starts, the next cycle executes
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_cmd) begin
            state <= S_EXEC;
          end
        end
        S_EXEC: state <= S_IDLE;
      endcase
    end
  end

  // Decode of the latched command block
  assign cmd_idx = condition_identifier[pcond_pkg::COND_IDX_W-1:0];
  assign sub_code = subcommand_parameters[pcond_pkg::PAR_SUB_MSB:0];
  assign save_req = subcommand_parameters[pcond_pkg::PAR_SAVE_BIT];
  assign enable_req = subcommand_parameters[pcond_pkg::PAR_ENABLE_BIT];

  always_comb begin
    is_set_timer = 1'b0;
    is_set_state = 1'b0;
    if (opcode == pcond_pkg::OP_SET_FEATURES && subcommand_select == pcond_pkg::SEL_POWER_COND) begin
      is_set_timer = (sub_code == pcond_pkg::SUB_SET_TIMER);
      is_set_state = (sub_code == pcond_pkg::SUB_SET_STATE);
    end
  end

  // Identifiers beyond the held conditions count as unsupported
  assign cond_ok = (condition_identifier < 8'(pcond_pkg::NUM_COND))
                   && cond_supported_i[cmd_idx] && cond_changeable_i[cmd_idx];

  always_comb begin
    abort_now = 1'b0;
    if (!(is_set_timer || is_set_state)) begin
      abort_now = 1'b1;
    end else if (!extended_power_conditions_i || !cond_ok) begin
      abort_now = 1'b1;
    end else if (save_req && !cond_savable_i[cmd_idx]) begin
      abort_now = 1'b1;
    end
  end

  timer_scaler u_scaler (
    .raw_i({timer_value_high, timer_value_low}),
    .units_min_i(subcommand_parameters[pcond_pkg::PAR_UNITS_BIT]),
    .ticks_o(scaled)
  );

  // New settings for the selected condition
  always_comb begin
    next_entry = settings[cmd_idx];
    if (is_set_timer) begin
      next_entry.cur_timer = scaled;
      next_entry.cur_en = enable_req && (scaled != pcond_pkg::TIMER_MIN);
      if (save_req) begin
        next_entry.sav_timer = next_entry.cur_timer;
        next_entry.sav_en = next_entry.cur_en;
      end
    end else begin
      next_entry.cur_en = enable_req;
      if (save_req) begin
        next_entry.sav_en = next_entry.cur_en;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < pcond_pkg::NUM_COND; i++) begin
        settings[i] <= '{pcond_pkg::TIMER_RESET, 1'b0, pcond_pkg::TIMER_RESET, 1'b0};
      end
    end else if (exec && !abort_now) begin
      settings[cmd_idx] <= next_entry;
    end
  end

  // Completion flags; a new command clears the previous outcome
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      abort_flag <= 1'b0;
      err_flag <= 1'b0;
    end else if (start_cmd) begin
      abort_flag <= 1'b0;
      err_flag <= 1'b0;
    end else if (exec) begin
      abort_flag <= abort_now;
      err_flag <= abort_now;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cmd_done_o <= 1'b0;
    end else begin
      cmd_done_o <= exec;
    end
  end

  assign busy_o = exec;

  // Read data is registered one cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tf_rdata_o <= pcond_pkg::REG_RESET;
    end else if (tf_req_i.rd) begin
      unique case (tf_req_i.addr)
        pcond_pkg::TF_FEATURE_ERROR: tf_rdata_o <= 8'(abort_flag) << pcond_pkg::ERR_ABORT_BIT;
        pcond_pkg::TF_COND_ID: tf_rdata_o <= condition_identifier;
        pcond_pkg::TF_PARAMS: tf_rdata_o <= subcommand_parameters;
        pcond_pkg::TF_TIMER_LOW: tf_rdata_o <= timer_value_low;
        pcond_pkg::TF_TIMER_HIGH: tf_rdata_o <= timer_value_high;
        pcond_pkg::TF_DRIVE_SEL: tf_rdata_o <= drive_select;
        pcond_pkg::TF_OPCODE_STATUS: tf_rdata_o <= status_byte(exec, err_flag);
        default: tf_rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      query_o <= '{pcond_pkg::TIMER_RESET, 1'b0, pcond_pkg::TIMER_RESET, 1'b0};
    end else begin
      query_o <= settings[query_cond_i];
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence seq_cmd_taken;
    start_cmd;
  endsequence

  sequence seq_exec_ok;
    exec && !abort_now;
  endsequence

  sequence seq_exec_abort;
    exec && abort_now;
  endsequence

  a_timer_dispatch: assert property (seq_exec_ok ##0 is_set_timer
    |=> settings[$past(cmd_idx)].cur_timer == $past(scaled))
    else $error("timer not stored after set-timer");

  a_other_cond_kept: assert property (exec && cmd_idx != 2'h0 |=> $stable(settings[0]))
    else $error("unselected condition changed");

  a_minute_scale: assert property (exec && subcommand_parameters[pcond_pkg::PAR_UNITS_BIT]
    && ({timer_value_high, timer_value_low} <= 16'h1999)
    |-> 26'(scaled) == 26'({timer_value_high, timer_value_low}) * 26'd600)
    else $error("minute value not scaled by 600");

  a_tick_scale: assert property (exec && !subcommand_parameters[7]
    |-> scaled == 22'({timer_value_high, timer_value_low}))
    else $error("tick value altered");

  a_enable_rule: assert property (seq_exec_ok ##0 is_set_timer
    |=> settings[$past(cmd_idx)].cur_en == ($past(enable_req) && $past(scaled) != 22'h0))
    else $error("current enable wrong after set-timer");

  a_save_copy: assert property (seq_exec_ok ##0 is_set_timer && save_req
    |=> settings[$past(cmd_idx)].sav_timer == settings[$past(cmd_idx)].cur_timer
    && settings[$past(cmd_idx)].sav_en == settings[$past(cmd_idx)].cur_en)
    else $error("saved setting not copied");

  a_clamp_range: assert property (scaled <= 22'h3BFFC4)
    else $error("timer beyond maximum");

  a_abort_kept: assert property (seq_exec_abort |=> $stable(settings[cmd_idx]))
    else $error("settings changed on abort");

  a_state_enable: assert property (seq_exec_ok ##0 is_set_state
    |=> settings[$past(cmd_idx)].cur_en == $past(enable_req)
    && settings[$past(cmd_idx)].cur_timer == $past(settings[cmd_idx].cur_timer))
    else $error("set-state enable wrong");

  a_state_save: assert property (seq_exec_ok ##0 is_set_state && save_req
    |=> settings[$past(cmd_idx)].sav_en == $past(enable_req))
    else $error("set-state save wrong");

  a_abort_flags: assert property (seq_cmd_taken ##1 abort_now
    |=> abort_flag && err_flag && !busy_o && cmd_done_o)
    else $error("abort flags not reported");

  a_busy_one: assert property (seq_cmd_taken |=> busy_o ##1 !busy_o)
    else $error("busy not exactly one cycle");

  a_cond_one_kept: assert property (exec && cmd_idx != 2'h1 |=> $stable(settings[1]))
    else $error("unselected condition one changed");

  a_abort_all: assert property (seq_exec_abort |=> $stable(settings[0]) && $stable(settings[1])
    && $stable(settings[2]) && $stable(settings[3]))
    else $error("a setting changed on abort");

  a_feature_off: assert property (exec && !extended_power_conditions_i
    |-> abort_now)
    else $error("command run with feature set off");

  a_unsavable_abort: assert property (exec && save_req && !cond_savable_i[cmd_idx]
    |-> abort_now)
    else $error("save accepted for unsavable condition");

  a_id_range: assert property (exec && condition_identifier >= 8'(pcond_pkg::NUM_COND)
    |-> abort_now)
    else $error("identifier beyond held conditions accepted");

  a_sub_decode: assert property (exec && sub_code != pcond_pkg::SUB_SET_TIMER
    && sub_code != pcond_pkg::SUB_SET_STATE |-> abort_now)
    else $error("unknown subcommand accepted");

  a_success_flags: assert property (seq_cmd_taken ##1 !abort_now
    |=> !abort_flag && !err_flag && cmd_done_o)
    else $error("flags raised on success");

  a_flags_cleared: assert property (seq_cmd_taken |=> !abort_flag && !err_flag)
    else $error("flags not cleared at command start");

  a_done_pulse: assert property (exec |=> cmd_done_o ##1 !cmd_done_o)
    else $error("done not a single pulse");

  a_status_byte: assert property (tf_req_i.rd && tf_req_i.addr == pcond_pkg::TF_OPCODE_STATUS
    |=> tf_rdata_o[pcond_pkg::ST_READY_BIT] && !tf_rdata_o[pcond_pkg::ST_FAULT_BIT]
    && tf_rdata_o[pcond_pkg::ST_ERR_BIT] == $past(err_flag) && tf_rdata_o[pcond_pkg::ST_BUSY_BIT] == $past(exec))
    else $error("status byte wrong");

  a_error_byte: assert property (tf_req_i.rd && tf_req_i.addr == pcond_pkg::TF_FEATURE_ERROR
    |=> tf_rdata_o[pcond_pkg::ERR_ABORT_BIT] == $past(abort_flag) && $countones(tf_rdata_o) == int'($past(abort_flag)))
    else $error("error byte wrong");

endmodule // power_condition_timer_cmd

`default_nettype wire

/* File: design/pcond_pkg.sv */
// Shared constants and types for the power-condition timer command block.
// Assumes a single 250 MHz clock domain and a same-clock task-file master.
`default_nettype none

package pcond_pkg;

  // Number of power conditions held and the width of their index
  localparam int NUM_COND = 4;
  localparam int COND_IDX_W = 2;

  // Task-file register addresses
  localparam logic [2:0] TF_FEATURE_ERROR = 3'h1;
  localparam logic [2:0] TF_COND_ID = 3'h2;
  localparam logic [2:0] TF_PARAMS = 3'h3;
  localparam logic [2:0] TF_TIMER_LOW = 3'h4;
  localparam logic [2:0] TF_TIMER_HIGH = 3'h5;
  localparam logic [2:0] TF_DRIVE_SEL = 3'h6;
  localparam logic [2:0] TF_OPCODE_STATUS = 3'h7;

  // Command codes
  localparam logic [7:0] OP_SET_FEATURES = 8'hEF;
  localparam logic [7:0] SEL_POWER_COND = 8'h4A;
  localparam logic [3:0] SUB_SET_TIMER = 4'h2;
  localparam logic [3:0] SUB_SET_STATE = 4'h3;

  // Field positions in the parameter byte
  localparam int PAR_UNITS_BIT = 7;
  localparam int PAR_ENABLE_BIT = 5;
  localparam int PAR_SAVE_BIT = 4;
  localparam int PAR_SUB_MSB = 3;

  // Field positions in error and status bytes
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_READY_BIT = 6;
  localparam int ST_FAULT_BIT = 5;
  localparam int ST_ERR_BIT = 0;

  // Timer range, in 100 ms ticks
  localparam int TIMER_W = 22;
  localparam int WIDE_W = 26;
  localparam logic [TIMER_W-1:0] TIMER_MAX = 22'h3BFFC4;
  localparam logic [TIMER_W-1:0] TIMER_MIN = 22'h000000;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 22'h000000;

  // Unit conversion derived from the two unit lengths
  localparam int TICK_MS = 100;
  localparam int MINUTE_MS = 60000;
  localparam logic [9:0] MIN_TO_TICKS = 10'(MINUTE_MS / TICK_MS);

  // Reset values of task-file registers
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic [TIMER_W-1:0] cur_timer;
    logic cur_en;
    logic [TIMER_W-1:0] sav_timer;
    logic sav_en;
  } cond_setting_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tf_req_s;

endpackage

`default_nettype wire

/* File: design/timer_scaler.sv */
// Converts a host timer value to 100 ms ticks and clamps it to the legal range.
// Purely combinational; the caller registers the result where it is stored.
`timescale 1ns/1ps
`default_nettype none

module timer_scaler (
  input wire logic [15:0] raw_i,
  input wire logic units_min_i,
  output logic [pcond_pkg::TIMER_W-1:0] ticks_o
);

  logic [pcond_pkg::WIDE_W-1:0] wide;

  always_comb begin
    if (units_min_i) begin
      wide = pcond_pkg::WIDE_W'(raw_i) * pcond_pkg::WIDE_W'(pcond_pkg::MIN_TO_TICKS);
    end else begin
      wide = pcond_pkg::WIDE_W'(raw_i);
    end
  end

  always_comb begin
    if (wide > pcond_pkg::WIDE_W'(pcond_pkg::TIMER_MAX)) begin
      ticks_o = pcond_pkg::TIMER_MAX;
    end else if (wide < pcond_pkg::WIDE_W'(pcond_pkg::TIMER_MIN)) begin
      ticks_o = pcond_pkg::TIMER_MIN;
    end else begin
      ticks_o = wide[pcond_pkg::TIMER_W-1:0];
    end
  end

endmodule // timer_scaler

`default_nettype wire

/* File: testbench/pcond_host.sv */
// Host-side model that drives the task-file request port of the device.
// Assumes the device samples requests on the rising edge of mclk_i.
`timescale 1ns/1ps
`default_nettype none

module pcond_host (
  input wire logic mclk_i,
  input wire logic [7:0] tf_rdata_i,
  output pcond_pkg::tf_req_s tf_req_o
);
  initial tf_req_o = '{wr: 1'b0, rd: 1'b0, addr: 3'h0, wdata: 8'h00};

  // One strobe cycle, then address and data are scrambled once released
  task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    tf_req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk_i);
    tf_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    access(1'b0, a, 8'h00);
    #1 d = tf_rdata_i;
  endtask

  // Loads the command block, then starts set-features
  task automatic command(input logic [7:0] id, input logic [7:0] par, input logic [15:0] t);
    wr_reg(pcond_pkg::TF_FEATURE_ERROR, pcond_pkg::SEL_POWER_COND);
    wr_reg(pcond_pkg::TF_COND_ID, id);
    wr_reg(pcond_pkg::TF_PARAMS, par);
    wr_reg(pcond_pkg::TF_TIMER_LOW, t[7:0]);
    wr_reg(pcond_pkg::TF_TIMER_HIGH, t[15:8]);
    wr_reg(pcond_pkg::TF_DRIVE_SEL, 8'hA0);
    wr_reg(pcond_pkg::TF_OPCODE_STATUS, pcond_pkg::OP_SET_FEATURES);
  endtask
endmodule // pcond_host

`default_nettype wire

/* File: testbench/power_condition_timer_cmd_bench.sv */
// Self-checking bench for the power-condition timer command block.
// Assumes the host model drives every task-file request.
`timescale 1ns/1ps
`default_nettype none

module power_condition_timer_cmd_bench;
  typedef struct packed {
    logic [7:0] id;
    logic [7:0] par;
    logic [15:0] timer;
    logic abort;
    pcond_pkg::cond_setting_s exp;
  } row_s;

  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ext_on = 1'b1;
  logic [pcond_pkg::NUM_COND-1:0] sup = 4'hF;
  logic [pcond_pkg::NUM_COND-1:0] chg = 4'h7;
  logic [pcond_pkg::NUM_COND-1:0] sav = 4'h3;
  logic [1:0] qsel = 2'h0;
  pcond_pkg::tf_req_s req;
  pcond_pkg::cond_setting_s query;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic busy;
  logic done;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  row_s rows [12];

  pcond_host host (.mclk_i(mclk_i), .tf_rdata_i(rdata), .tf_req_o(req));

  power_condition_timer_cmd dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .tf_req_i(req), .tf_rdata_o(rdata),
    .extended_power_conditions_i(ext_on), .cond_supported_i(sup), .cond_changeable_i(chg),
    .cond_savable_i(sav), .query_cond_i(qsel), .query_o(query), .busy_o(busy), .cmd_done_o(done)
  );

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic see(input logic [1:0] idx, input pcond_pkg::cond_setting_s exp);
    @(posedge mclk_i);
    qsel <= idx;
    repeat (2) @(posedge mclk_i);
    #1 chk(64'(query), 64'(exp));
  endtask

  // Busy in the execute cycle only, done one cycle later, then flags
  task automatic settle(input logic ab);
    #1 chk(64'(busy), 64'h1);
    @(posedge mclk_i);
    #1 chk(64'({busy, done}), 64'h1);
    host.rd_reg(pcond_pkg::TF_FEATURE_ERROR, rv);
    chk(64'(rv), ab ? 64'h04 : 64'h00);
    host.rd_reg(pcond_pkg::TF_OPCODE_STATUS, rv);
    chk(64'(rv & 8'hE1), ab ? 64'h41 : 64'h40);
  endtask

  task automatic run(input logic [7:0] id, input logic [7:0] par, input logic [15:0] t, input logic ab);
    host.command(id, par, t);
    settle(ab);
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    see(2'h0, '0);
    for (int a = 0; a < 7; a++) begin
      host.rd_reg(3'(a), rv);
      chk(64'(rv), 64'(pcond_pkg::REG_RESET));
    end
    host.rd_reg(pcond_pkg::TF_OPCODE_STATUS, rv);
    chk(64'(rv & 8'hE1), 64'h40);
  endtask

  initial begin
    rows = '{
      '{8'h00, 8'h32, 16'h1234, 1'b0, '{22'h001234, 1'b1, 22'h001234, 1'b1}},
      '{8'h01, 8'hB2, 16'h0064, 1'b0, '{22'h00EA60, 1'b1, 22'h00EA60, 1'b1}},
      '{8'h01, 8'hA2, 16'h199A, 1'b0, '{22'h3BFFC4, 1'b1, 22'h00EA60, 1'b1}},
      '{8'h00, 8'h22, 16'h0000, 1'b0, '{22'h000000, 1'b0, 22'h001234, 1'b1}},
      '{8'h00, 8'h13, 16'h0000, 1'b0, '{22'h000000, 1'b0, 22'h001234, 1'b0}},
      '{8'h00, 8'h33, 16'h0000, 1'b0, '{22'h000000, 1'b1, 22'h001234, 1'b1}},
      '{8'h02, 8'hA2, 16'h1999, 1'b0, '{22'h3BFE98, 1'b1, 22'h000000, 1'b0}},
      '{8'h02, 8'h12, 16'h0005, 1'b1, '{22'h3BFE98, 1'b1, 22'h000000, 1'b0}},
      '{8'h03, 8'h22, 16'h0005, 1'b1, '{22'h000000, 1'b0, 22'h000000, 1'b0}},
      '{8'h01, 8'h35, 16'h0001, 1'b1, '{22'h3BFFC4, 1'b1, 22'h00EA60, 1'b1}},
      '{8'h02, 8'h02, 16'hFFFF, 1'b0, '{22'h00FFFF, 1'b0, 22'h000000, 1'b0}},
      '{8'h04, 8'h22, 16'h0001, 1'b1, '{22'h000000, 1'b1, 22'h001234, 1'b1}}
    };
    do_reset();
    foreach (rows[i]) begin
      run(rows[i].id, rows[i].par, rows[i].timer, rows[i].abort);
      see(rows[i].id[1:0], rows[i].exp);
    end
    // Untouched condition keeps its reset setting
    see(2'h3, '0);
    // Feature set switched off refuses a legal request
    @(posedge mclk_i);
    ext_on <= 1'b0;
    run(8'h00, 8'h32, 16'h0010, 1'b1);
    see(2'h0, '{22'h000000, 1'b1, 22'h001234, 1'b1});
    @(posedge mclk_i);
    ext_on <= 1'b1;
    run(8'h00, 8'h30, 16'h0010, 1'b1);
    host.rd_reg(pcond_pkg::TF_TIMER_LOW, rv);
    chk(64'(rv), 64'h10);
    // Wrong feature code, then wrong opcode, over a legal command block
    host.wr_reg(pcond_pkg::TF_PARAMS, 8'h32);
    host.wr_reg(pcond_pkg::TF_FEATURE_ERROR, 8'h00);
    host.wr_reg(pcond_pkg::TF_OPCODE_STATUS, pcond_pkg::OP_SET_FEATURES);
    settle(1'b1);
    host.wr_reg(pcond_pkg::TF_FEATURE_ERROR, pcond_pkg::SEL_POWER_COND);
    host.wr_reg(pcond_pkg::TF_OPCODE_STATUS, 8'h00);
    settle(1'b1);
    see(2'h0, '{22'h000000, 1'b1, 22'h001234, 1'b1});
    // Reset in mid-run clears every setting
    do_reset();
    see(2'h1, '0);
    stop_test();
  end
endmodule // power_condition_timer_cmd_bench

`default_nettype wire
